// [sbl_pkg.sv]
// Purpose: Constants and types of the strap sampled boot loader
// Assumes: One 125 MHz clock, synchronous active-low reset
// Notes:   Times are kept in microseconds; counts derive from them
package sbl_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int SYNC_STAGES    = 2;
  localparam int T_NAND_RST_US  = 25;
  localparam int T_NAND_READ_US = 50;
  localparam int CYC_NAND_RST   = T_NAND_RST_US * CLK_MHZ;
  localparam int CYC_NAND_READ  = T_NAND_READ_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Strap layout and encodings
  // ---------------------------------------------------------------
  localparam int AON_BIT = 7;
  localparam int ECC_BIT = 6;
  localparam int SRC_HI  = 5;
  localparam int SRC_LO  = 3;
  localparam int REF_HI  = 1;
  localparam int REF_LO  = 0;
  localparam logic [7:0] STRAP_RESET  = 8'h12;
  localparam logic [2:0] SRC_DRAM     = 3'h0;
  localparam logic [2:0] SRC_SPI_STD  = 3'h1;
  localparam logic [2:0] SRC_RSVD     = 3'h2;
  localparam logic [2:0] SRC_SPI_PAGE = 3'h3;
  localparam logic [2:0] SRC_NAND     = 3'h4;
  localparam logic [1:0] REF_13M      = 2'h0;
  localparam logic [1:0] REF_19M2     = 2'h1;
  localparam logic [1:0] REF_24M      = 2'h2;
  localparam logic [1:0] REF_27M      = 2'h3;

  // ---------------------------------------------------------------
  // Flash commands and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0]  OP_SPI_STD      = 8'h03;
  localparam logic [7:0]  OP_SPI_PAGE     = 8'he8;
  localparam logic [7:0]  NAND_RESET      = 8'hff;
  localparam logic [7:0]  NAND_READ       = 8'h00;
  localparam logic [7:0]  NAND_CONFIRM    = 8'h30;
  localparam logic [7:0]  NAND_ADDR       = 8'h00;
  localparam logic [2:0]  NAND_ADDR_LAST  = 3'h4;
  localparam logic [1:0]  NAND_BLK_LAST   = 2'h3;
  localparam logic [31:0] NAND_PAGE_BYTES = 32'h0000_0800;
  localparam logic [31:0] NAND_ECC_BYTES  = 32'h0000_0200;
  localparam logic [31:0] WORD_BYTES      = 32'h0000_0004;
  localparam logic [11:0] CMD_LEN_NONE    = 12'h000;
  localparam logic [1:0]  CMD_BYTE        = 2'h0;
  localparam logic [1:0]  CMD_ADDR        = 2'h1;
  localparam logic [1:0]  CMD_NREAD       = 2'h2;
  localparam logic [1:0]  CMD_SPI         = 2'h3;
  localparam logic [1:0]  BUF_DEPTH       = 2'h2;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_CAPT, S_SEL, S_NRST, S_W25, S_N00, S_NADR, S_N30, S_W50,
    S_NRD, S_SPI, S_COPY, S_ECC, S_REL, S_FAIL, S_PARK
  } sbl_state_t;

  typedef struct packed {
    sbl_state_t  st;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  strap;
    logic        strap_valid;
    logic [15:0] wait_cnt;
    logic [2:0]  addr_idx;
    logic [1:0]  blk;
    logic [31:0] blk_bytes;
    logic        hdr;
    logic [31:0] remain;
    logic [29:0] waddr;
    logic [31:0] buf0;
    logic [31:0] buf1;
    logic        wp;
    logic        rp;
    logic [1:0]  cnt;
    logic [1:0]  cmd_kind;
    logic [7:0]  cmd_byte;
    logic [11:0] cmd_len;
    logic        cpu_rel;
    logic        fail;
  } sbl_ctl_t;

endpackage

// [sbl_boot_loader.sv]
// Purpose: Strap capture and hardware boot loader
// Assumes: Flash front end and DRAM port share CLOCK
// Notes:   First stream word is the total image byte count
// Function
// - Capture boot straps from display data pins at reset release
// - Leave display data pins undriven during reset
// - Strap bit 7 enables always-on power domain, default off
// - Strap bit 6 enables NAND boot ECC, default off
// - Strap bits 5..3 choose boot source, reserved default
// - Strap bits 1..0 give reference frequency, 24 MHz default
// - Move received words into DRAM until the byte count expires
// - Hold main processor in reset while loading
// - Release main processor when byte count expires; NAND releases at end of page or ECC block
// - Source 000 skips loader, releases processor at once
// - Source 011 reads serial flash with opcode e8
// - Source 001 reads serial flash with opcode 03
// - NAND boot sends reset ff then waits 25 us
// - NAND then sends 00, five zero address bytes, 30
// - Wait 50 us, then read one 2 Kbyte page
// - With ECC, read page as four 512 byte blocks
// - ECC error keeps processor in reset forever
`timescale 1ns/1ps
module sbl_boot_loader
  import sbl_pkg::*;
#(
  parameter int NAND_READ_WAIT_CYC = CYC_NAND_READ
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  DIP_DATA_I,
  output logic      [7:0]  DIP_DATA_O,
  output logic      [7:0]  DIP_DATA_OE,
  output logic             STRAP_VALID,
  output logic             AON_EN,
  output logic             NAND_ECC_EN,
  output logic      [2:0]  BOOT_SRC,
  output logic      [1:0]  REF_CLK_SEL,
  output logic             FE_CMD_VALID,
  input  wire logic        FE_CMD_READY,
  output logic      [1:0]  FE_CMD_KIND,
  output logic      [7:0]  FE_CMD_BYTE,
  output logic      [11:0] FE_CMD_LEN,
  input  wire logic        RX_VALID,
  output logic             RX_READY,
  input  wire logic [31:0] RX_DATA,
  input  wire logic        ECC_DONE,
  input  wire logic        ECC_ERR,
  output logic             DRAM_VALID,
  input  wire logic        DRAM_READY,
  output logic      [31:0] DRAM_ADDR,
  output logic      [31:0] DRAM_DATA,
  output logic             CPU_RST_N,
  output logic             BOOT_BUSY,
  output logic             BOOT_ERR
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] sub4(input logic [31:0] v);
    sub4 = (v < WORD_BYTES) ? '0 : v - WORD_BYTES;
  endfunction

  function automatic logic [21:0] cmd_for(input sbl_state_t s,
                                          input logic [2:0] src,
                                          input logic ecc);
    cmd_for = {CMD_BYTE, NAND_READ, CMD_LEN_NONE};
    case (s)
      S_NRST: cmd_for = {CMD_BYTE, NAND_RESET, CMD_LEN_NONE};
      S_NADR: cmd_for = {CMD_ADDR, NAND_ADDR, CMD_LEN_NONE};
      S_N30:  cmd_for = {CMD_BYTE, NAND_CONFIRM, CMD_LEN_NONE};
      S_NRD:  cmd_for = {CMD_NREAD, NAND_READ,
                         ecc ? NAND_ECC_BYTES[11:0]
                             : NAND_PAGE_BYTES[11:0]};
      S_SPI:  cmd_for = {CMD_SPI,
                         (src == SRC_SPI_PAGE) ? OP_SPI_PAGE
                                               : OP_SPI_STD,
                         CMD_LEN_NONE};
      default: cmd_for = {CMD_BYTE, NAND_READ, CMD_LEN_NONE};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State and flow terms
  // ---------------------------------------------------------------
  sbl_ctl_t   ctl_reg;
  sbl_ctl_t   ctl_next;
  logic       is_nand;
  logic       use_ecc;
  logic       keep;
  logic       cmd_state;
  logic       cmd_ok;
  logic       push;
  logic       wr;
  logic       pop;

  assign is_nand   = ctl_reg.strap[SRC_HI:SRC_LO] == SRC_NAND;
  assign use_ecc   = is_nand && ctl_reg.strap[ECC_BIT];
  assign keep      = ctl_reg.hdr || (ctl_reg.remain != '0);
  assign cmd_state = ctl_reg.st inside {S_NRST, S_N00, S_NADR,
                                        S_N30, S_NRD, S_SPI};
  assign cmd_ok    = cmd_state && FE_CMD_READY;
  assign RX_READY  = (ctl_reg.st == S_COPY) && (ctl_reg.cnt != BUF_DEPTH)
                     && (is_nand ? (ctl_reg.blk_bytes != '0) : keep);
  assign push      = RX_VALID && RX_READY;
  assign wr        = push && keep;
  assign pop       = DRAM_VALID && DRAM_READY;

  always_comb begin
    ctl_next       = ctl_reg;
    ctl_next.sync1 = DIP_DATA_I;
    ctl_next.sync2 = ctl_reg.sync1;
    // Two-entry buffer between receive FIFO and DRAM
    if (wr) begin
      if (ctl_reg.wp) begin
        ctl_next.buf1 = RX_DATA;
      end else begin
        ctl_next.buf0 = RX_DATA;
      end
      ctl_next.wp = ~ctl_reg.wp;
      if (ctl_reg.hdr) begin
        ctl_next.hdr    = 1'b0;
        ctl_next.remain = sub4(RX_DATA);
      end else begin
        ctl_next.remain = sub4(ctl_reg.remain);
      end
    end
    if (push && is_nand) begin
      ctl_next.blk_bytes = sub4(ctl_reg.blk_bytes);
    end
    if (pop) begin
      ctl_next.rp    = ~ctl_reg.rp;
      ctl_next.waddr = ctl_reg.waddr + 30'h0000_0001;
    end
    case ({wr, pop})
      2'h2:    ctl_next.cnt = ctl_reg.cnt + 2'h1;
      2'h1:    ctl_next.cnt = ctl_reg.cnt - 2'h1;
      default: ctl_next.cnt = ctl_reg.cnt;
    endcase
    // Boot sequence
    case (ctl_reg.st)
      S_CAPT: begin
        if (ctl_reg.wait_cnt == 16'(SYNC_STAGES)) begin
          ctl_next.strap       = ctl_reg.sync2;
          ctl_next.strap_valid = 1'b1;
          ctl_next.st          = S_SEL;
        end
      end
      S_SEL: begin
        case (ctl_reg.strap[SRC_HI:SRC_LO])
          SRC_DRAM:     ctl_next.st = S_REL;
          SRC_SPI_STD:  ctl_next.st = S_SPI;
          SRC_SPI_PAGE: ctl_next.st = S_SPI;
          SRC_NAND:     ctl_next.st = S_NRST;
          default:      ctl_next.st = S_PARK;
        endcase
      end
      S_NRST: if (cmd_ok) ctl_next.st = S_W25;
      S_W25: begin
        if (ctl_reg.wait_cnt == 16'(CYC_NAND_RST - 1)) begin
          ctl_next.st = S_N00;
        end
      end
      S_N00: begin
        if (cmd_ok) begin
          ctl_next.st       = S_NADR;
          ctl_next.addr_idx = '0;
        end
      end
      S_NADR: begin
        if (cmd_ok) begin
          if (ctl_reg.addr_idx == NAND_ADDR_LAST) begin
            ctl_next.st = S_N30;
          end else begin
            ctl_next.addr_idx = ctl_reg.addr_idx + 3'h1;
          end
        end
      end
      S_N30: if (cmd_ok) ctl_next.st = S_W50;
      S_W50: begin
        if (ctl_reg.wait_cnt == 16'(NAND_READ_WAIT_CYC - 1)) begin
          ctl_next.st = S_NRD;
        end
      end
      S_NRD: begin
        if (cmd_ok) begin
          ctl_next.st        = S_COPY;
          ctl_next.blk_bytes = use_ecc ? NAND_ECC_BYTES
                                       : NAND_PAGE_BYTES;
        end
      end
      S_SPI: if (cmd_ok) ctl_next.st = S_COPY;
      S_COPY: begin
        if (is_nand) begin
          if (ctl_next.blk_bytes == '0 && ctl_next.cnt == 2'h0) begin
            ctl_next.st = use_ecc ? S_ECC : S_REL;
          end
        end else if (!ctl_next.hdr && ctl_next.remain == '0 &&
                     ctl_next.cnt == 2'h0) begin
          ctl_next.st = S_REL;
        end
      end
      S_ECC: begin
        if (ECC_DONE) begin
          if (ECC_ERR) begin
            ctl_next.st = S_FAIL;
          end else if (ctl_reg.blk == NAND_BLK_LAST ||
                       ctl_reg.remain == '0) begin
            ctl_next.st = S_REL;
          end else begin
            ctl_next.blk = ctl_reg.blk + 2'h1;
            ctl_next.st  = S_NRD;
          end
        end
      end
      default: ctl_next.st = ctl_reg.st;
    endcase
    ctl_next.wait_cnt = (ctl_next.st != ctl_reg.st) ? '0
                        : ctl_reg.wait_cnt + 16'h0001;
    {ctl_next.cmd_kind, ctl_next.cmd_byte, ctl_next.cmd_len} =
      cmd_for(ctl_next.st, ctl_next.strap[SRC_HI:SRC_LO],
              ctl_next.strap[ECC_BIT]);
    ctl_next.cpu_rel = ctl_next.st == S_REL;
    ctl_next.fail    = ctl_next.st == S_FAIL;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctl_reg       <= '0;
      ctl_reg.strap <= STRAP_RESET;
      ctl_reg.hdr   <= 1'b1;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign DIP_DATA_O   = '0;
  assign DIP_DATA_OE  = '0;
  assign STRAP_VALID  = ctl_reg.strap_valid;
  assign AON_EN       = ctl_reg.strap[AON_BIT];
  assign NAND_ECC_EN  = ctl_reg.strap[ECC_BIT];
  assign BOOT_SRC     = ctl_reg.strap[SRC_HI:SRC_LO];
  assign REF_CLK_SEL  = ctl_reg.strap[REF_HI:REF_LO];
  assign FE_CMD_VALID = cmd_state;
  assign FE_CMD_KIND  = ctl_reg.cmd_kind;
  assign FE_CMD_BYTE  = ctl_reg.cmd_byte;
  assign FE_CMD_LEN   = ctl_reg.cmd_len;
  assign DRAM_VALID   = ctl_reg.cnt != 2'h0;
  assign DRAM_ADDR    = {ctl_reg.waddr, 2'h0};
  assign DRAM_DATA    = ctl_reg.rp ? ctl_reg.buf1 : ctl_reg.buf0;
  assign CPU_RST_N    = ctl_reg.cpu_rel;
  assign BOOT_BUSY    = ctl_reg.st != S_REL;
  assign BOOT_ERR     = ctl_reg.fail;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_copy_end;
    (ctl_reg.st == S_COPY) ##1 (ctl_reg.st == S_REL);
  endsequence
  sequence s_ecc_bad;
    (ctl_reg.st == S_ECC) && ECC_DONE && ECC_ERR;
  endsequence

  property p_pins_free;
    DIP_DATA_OE == '0;
  endproperty
  a_pins_free: assert property (p_pins_free)
    else $error("strap pins driven");
  property p_strap_hold;
    STRAP_VALID && $past(STRAP_VALID) |-> $stable(ctl_reg.strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap changed after capture");
  property p_cpu_held;
    BOOT_BUSY |-> !CPU_RST_N;
  endproperty
  a_cpu_held: assert property (p_cpu_held)
    else $error("processor released during load");
  property p_dram_skip;
    (ctl_reg.st == S_SEL) && (BOOT_SRC == SRC_DRAM) |=> CPU_RST_N;
  endproperty
  a_dram_skip: assert property (p_dram_skip)
    else $error("debug source did not release at once");
  property p_op_page;
    FE_CMD_VALID && FE_CMD_KIND == CMD_SPI && BOOT_SRC == SRC_SPI_PAGE
      |-> FE_CMD_BYTE == OP_SPI_PAGE;
  endproperty
  a_op_page: assert property (p_op_page)
    else $error("wrong page flash opcode");
  property p_op_std;
    FE_CMD_VALID && FE_CMD_KIND == CMD_SPI && BOOT_SRC == SRC_SPI_STD
      |-> FE_CMD_BYTE == OP_SPI_STD;
  endproperty
  a_op_std: assert property (p_op_std)
    else $error("wrong standard flash opcode");
  property p_nand_first;
    (ctl_reg.st == S_SEL) && (BOOT_SRC == SRC_NAND)
      |=> FE_CMD_VALID && FE_CMD_BYTE == NAND_RESET;
  endproperty
  a_nand_first: assert property (p_nand_first)
    else $error("NAND boot did not start with reset");
  property p_wait25;
    (ctl_reg.st == S_W25) && (ctl_next.st != S_W25)
      |-> ctl_reg.wait_cnt == 16'(CYC_NAND_RST - 1);
  endproperty
  a_wait25: assert property (p_wait25)
    else $error("NAND reset wait has wrong length");
  property p_addr_zero;
    FE_CMD_VALID && FE_CMD_KIND == CMD_ADDR |-> FE_CMD_BYTE == NAND_ADDR;
  endproperty
  a_addr_zero: assert property (p_addr_zero)
    else $error("NAND address byte not zero");
  property p_ecc_stuck;
    s_ecc_bad |=> (BOOT_ERR && !CPU_RST_N)[*8];
  endproperty
  a_ecc_stuck: assert property (p_ecc_stuck)
    else $error("ECC error did not hold processor in reset");
  property p_release;
    s_copy_end |-> CPU_RST_N;
  endproperty
  a_release: assert property (p_release)
    else $error("processor not released at count end");
  property p_copy;
    wr |=> DRAM_VALID;
  endproperty
  a_copy: assert property (p_copy)
    else $error("received word not offered to DRAM");

endmodule

// [sbl_flash_model.sv]
// Purpose: Flash front end and receive FIFO model for the boot loader
// Assumes: Outputs change 1 ns after the rising edge
// Notes:   Word 0 of the stream is the image byte count
`timescale 1ns/1ps
module sbl_flash_model
  import sbl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic [31:0] img,
  input  wire logic [31:0] seed,
  input  wire logic [2:0]  bad_blk,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [11:0] cmd_len,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic      [31:0] rx_data,
  output logic             ecc_done,
  output logic             ecc_err
);
  int unsigned left = 0;
  int unsigned idx  = 0;
  int unsigned wt   = 0;
  int unsigned blk  = 0;
  logic        took;
  logic        ecc_mode = 1'b0;

  initial begin
    {cmd_ready, rx_valid, ecc_done, ecc_err} = 4'h0;
    rx_data = 32'h0000_0000;
  end

  always @(posedge clock) begin
    took = rx_valid && rx_ready;
    if (!rst_n) begin
      left = 0;
      idx  = 0;
      blk  = 0;
      wt   = 0;
    end else begin
      if (took) begin
        idx++;
        left--;
        if (left == 0 && ecc_mode) wt = 30;
      end
      if (cmd_valid && cmd_ready && cmd_kind == CMD_SPI) left = 32'hFFFF_FFFF;
      if (cmd_valid && cmd_ready && cmd_kind == CMD_NREAD) begin
        left     = cmd_len / 4;
        ecc_mode = cmd_len == NAND_ECC_BYTES[11:0];
      end
    end
    #1;
    ecc_done = 1'b0;
    ecc_err  = ~ecc_err;
    if (wt == 1) begin
      ecc_done = 1'b1;
      ecc_err  = blk == bad_blk;
      blk++;
    end
    if (wt > 0) wt--;
    cmd_ready = !stall;
    if (!rx_valid || took || !rst_n) begin
      rx_valid = left > 0 && !stall && rst_n;
      rx_data  = !rx_valid ? ~rx_data : idx == 0 ? img : idx * 32'h0101_0101 ^ seed;
    end
  end
endmodule

// [sbl_boot_loader_bench.sv]
// Purpose: Self-checking bench of the strap sampled boot loader
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Each case resets the block with its own strap byte
`timescale 1ns/1ps
module sbl_boot_loader_bench
  import sbl_pkg::*;
;
  localparam int RD_WAIT = 20;
  logic        CLOCK, RST_N, STRAP_VALID, AON_EN, NAND_ECC_EN, CPU_RST_N;
  logic        FE_CMD_VALID, FE_CMD_READY, RX_VALID, RX_READY, ECC_DONE;
  logic        ECC_ERR, DRAM_VALID, DRAM_READY, BOOT_BUSY, BOOT_ERR, stall;
  logic [7:0]  DIP_DATA_I, DIP_DATA_O, DIP_DATA_OE, FE_CMD_BYTE;
  logic [2:0]  BOOT_SRC, bad_blk;
  logic [1:0]  REF_CLK_SEL, FE_CMD_KIND;
  logic [11:0] FE_CMD_LEN;
  logic [31:0] RX_DATA, DRAM_ADDR, DRAM_DATA, img, seed, rs;
  logic [21:0] cq[$];
  logic [63:0] wq[$];
  int          bad_count, n_checks, cyc, t_ff, t_cf;

  sbl_boot_loader #(.NAND_READ_WAIT_CYC(RD_WAIT)) sbl_boot_loader_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .DIP_DATA_I(DIP_DATA_I),
    .DIP_DATA_O(DIP_DATA_O), .DIP_DATA_OE(DIP_DATA_OE),
    .STRAP_VALID(STRAP_VALID), .AON_EN(AON_EN), .NAND_ECC_EN(NAND_ECC_EN),
    .BOOT_SRC(BOOT_SRC), .REF_CLK_SEL(REF_CLK_SEL),
    .FE_CMD_VALID(FE_CMD_VALID), .FE_CMD_READY(FE_CMD_READY),
    .FE_CMD_KIND(FE_CMD_KIND), .FE_CMD_BYTE(FE_CMD_BYTE),
    .FE_CMD_LEN(FE_CMD_LEN), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .RX_DATA(RX_DATA), .ECC_DONE(ECC_DONE), .ECC_ERR(ECC_ERR),
    .DRAM_VALID(DRAM_VALID), .DRAM_READY(DRAM_READY),
    .DRAM_ADDR(DRAM_ADDR), .DRAM_DATA(DRAM_DATA), .CPU_RST_N(CPU_RST_N),
    .BOOT_BUSY(BOOT_BUSY), .BOOT_ERR(BOOT_ERR)
  );

  sbl_flash_model sbl_flash_model_inst (
    .clock(CLOCK), .rst_n(RST_N), .stall(stall), .img(img), .seed(seed),
    .bad_blk(bad_blk), .cmd_valid(FE_CMD_VALID), .cmd_ready(FE_CMD_READY),
    .cmd_kind(FE_CMD_KIND), .cmd_len(FE_CMD_LEN), .rx_valid(RX_VALID),
    .rx_ready(RX_READY), .rx_data(RX_DATA), .ecc_done(ECC_DONE),
    .ecc_err(ECC_ERR)
  );

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    #1;
    stall      = (rnd() & 32'h0000_0003) == 32'h0000_0000;
    DRAM_READY = (rnd() & 32'h0000_0003) != 32'h0000_0000;
  end

  // Command and DRAM write monitors
  always @(posedge CLOCK) begin
    cyc++;
    if (RST_N === 1'b1 && FE_CMD_VALID === 1'b1 && FE_CMD_READY) begin
      chk("cmd_expected", 1, cq.size() > 0);
      if (cq.size() > 0) chk("cmd", cq.pop_front(), {FE_CMD_KIND, FE_CMD_KIND == CMD_NREAD ? 8'h00 : FE_CMD_BYTE, FE_CMD_LEN});
      if (FE_CMD_KIND == CMD_BYTE && FE_CMD_BYTE == NAND_RESET) t_ff = cyc;
      if (FE_CMD_KIND == CMD_BYTE && FE_CMD_BYTE == NAND_READ) begin
        chk("reset_wait", 1, cyc - t_ff >= CYC_NAND_RST && cyc - t_ff < CYC_NAND_RST + 60);
      end
      if (FE_CMD_KIND == CMD_NREAD && t_cf > 0) begin
        chk("read_wait", 1, cyc - t_cf >= RD_WAIT && cyc - t_cf < RD_WAIT + 60);
        t_cf = 0;
      end
      if (FE_CMD_KIND == CMD_BYTE && FE_CMD_BYTE == NAND_CONFIRM) t_cf = cyc;
    end
    if (RST_N === 1'b1 && DRAM_VALID === 1'b1 && DRAM_READY) begin
      chk("cpu_held", 0, CPU_RST_N);
      chk("word_expected", 1, wq.size() > 0);
      if (wq.size() > 0) chk("dram_word", wq.pop_front(), {DRAM_ADDR, DRAM_DATA});
    end
  end

  task automatic boot(input logic [7:0] strap, input int n, input int bad);
    int         nw, lim, b;
    logic [2:0] src;
    logic       rel;
    src = strap[5:3];
    rel = src != SRC_RSVD && bad > 3;
    RST_N = 1'b0;
    DIP_DATA_I = strap;
    img = n;
    bad_blk = bad[2:0];
    seed = rnd();
    nw = 0;
    repeat (12) @(posedge CLOCK);
    #1;
    chk("reset_outs", {3'h0, SRC_RSVD, REF_24M, 5'h01, 8'h00}, {STRAP_VALID, AON_EN, NAND_ECC_EN, BOOT_SRC, REF_CLK_SEL, FE_CMD_VALID, DRAM_VALID, CPU_RST_N, BOOT_ERR, BOOT_BUSY, DIP_DATA_OE});
    if (src == SRC_SPI_STD || src == SRC_SPI_PAGE) begin
      cq.push_back({CMD_SPI, (src == SRC_SPI_STD) ? OP_SPI_STD : OP_SPI_PAGE, CMD_LEN_NONE});
      nw = n / 4;
    end
    if (src == SRC_NAND) begin
      cq.push_back({CMD_BYTE, NAND_RESET, CMD_LEN_NONE});
      cq.push_back({CMD_BYTE, NAND_READ, CMD_LEN_NONE});
      repeat (5) cq.push_back({CMD_ADDR, NAND_ADDR, CMD_LEN_NONE});
      cq.push_back({CMD_BYTE, NAND_CONFIRM, CMD_LEN_NONE});
      if (strap[ECC_BIT]) begin
        for (b = 0; b < 4 && b <= bad; b++) cq.push_back({CMD_NREAD, 8'h00, NAND_ECC_BYTES[11:0]});
        nw = (bad > 3) ? 512 : (bad + 1) * 128;
      end else begin
        cq.push_back({CMD_NREAD, 8'h00, NAND_PAGE_BYTES[11:0]});
        nw = 512;
      end
      if (n / 4 < nw) nw = n / 4;
    end
    for (b = 0; b < nw; b++) wq.push_back({32'(b * 4), (b == 0) ? 32'(n) : 32'(b) * 32'h0101_0101 ^ seed});
    RST_N = 1'b1;
    repeat (6) @(posedge CLOCK);
    #1;
    chk("straps", {1'b1, strap[7:3], strap[1:0]}, {STRAP_VALID, AON_EN, NAND_ECC_EN, BOOT_SRC, REF_CLK_SEL});
    chk("cpu_early", src == SRC_DRAM, CPU_RST_N);
    DIP_DATA_I = ~strap;
    lim = (src == SRC_RSVD) ? 300 : 20000;
    while (CPU_RST_N !== 1'b1 && BOOT_ERR !== 1'b1 && lim > 0) begin
      @(posedge CLOCK);
      #1;
      lim--;
    end
    repeat (20) @(posedge CLOCK);
    #1;
    chk("end_state", {rel, !rel, bad < 4}, {CPU_RST_N, BOOT_BUSY, BOOT_ERR});
    chk("cmds_left", 0, cq.size());
    chk("words_left", 0, wq.size());
    chk("pins_out", 0, DIP_DATA_O);
    chk("straps_held", {strap, 8'h00}, {AON_EN, NAND_ECC_EN, BOOT_SRC, strap[2], REF_CLK_SEL, DIP_DATA_OE});
  endtask

  initial begin
    repeat (60000) @(posedge CLOCK);
    bad_count++;
    end_of_test();
  end

  initial begin
    rs = 32'h0000_14BD;
    {bad_count, n_checks, cyc, t_ff, t_cf} = '0;
    RST_N = 1'b0;
    DIP_DATA_I = STRAP_RESET;
    {stall, DRAM_READY} = 2'h0;
    {img, seed} = 64'h0000_0000_0000_0000;
    bad_blk = 3'h7;
    boot(8'h00, 4, 7);
    boot(8'h89, 8 + 4 * (rnd() % 30), 7);
    boot(8'h1A, 8 + 4 * (rnd() % 30), 7);
    boot(8'h23, 8 + 4 * (rnd() % 30), 7);
    boot(8'h60, 2048, 7);
    boot(8'hE4, 2048, 1);
    boot(8'h12, 40, 7);
    end_of_test();
  end
endmodule
